// ===== design/lfis_top.sv
// Latched fault and interrupt status bank with its three mask bits
`timescale 1ns/1ns
`include "lfis_defines.svh"

module lfis_top (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire lfis_pkg::lfis_evt_t evtIn,
    input  wire lfis_pkg::lfis_evt_t srcMask,
    input  wire lfis_pkg::lfis_req_t req,
    output      lfis_pkg::lfis_rsp_t rsp_r,
    output      lfis_pkg::lfis_evt_t live_r,
    output      logic                faultIrq_r,
    output      logic                adcCh1OverloadMask_r,
    output      logic                adcCh2OverloadMask_r
);
    import lfis_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic       rstMeta_r;
    logic       rstN;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= `LFIS_RST_BIT;
            rstN      <= `LFIS_RST_BIT;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstN      <= rstMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Source synchronisers
    // ------------------------------------------------------------
    // Detectors sit in the analog domain; the second stage doubles as the live copy
    lfis_evt_t  evtMeta_r;
    lfis_evt_t  evt;

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            evtMeta_r <= '0;
            live_r    <= '0;
        end
        else
        begin
            evtMeta_r <= evtIn;
            live_r    <= evtMeta_r;
        end
    end

    assign evt = live_r;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] readByte(
        input logic [7:0] addr,
        input lfis_evt_t  fl,
        input logic       m1,
        input logic       m2,
        input logic       mr
    );
        logic [7:0] b;
        b = `LFIS_RST_BYTE;
        case (addr)
            `LFIS_ADDR_IRQ_CLOCK_PLL:
            begin
                b[`LFIS_BIT_CLK_ERR]  = fl.clkErr;
                b[`LFIS_BIT_PLL_LOCK] = fl.pllLock;
            end
            `LFIS_ADDR_OUT_CH1:
            begin
                b[`LFIS_BIT_SC_POS]    = fl.ch1ScPos;
                b[`LFIS_BIT_SC_NEG]    = fl.ch1ScNeg;
                b[`LFIS_BIT_VG_POS]    = fl.ch1VgPos;
                b[`LFIS_BIT_VG_NEG]    = fl.ch1VgNeg;
                b[`LFIS_BIT_ADC1_MASK] = m1;
                b[`LFIS_BIT_ADC2_MASK] = m2;
            end
            `LFIS_ADDR_OUT_CH2:
            begin
                b[`LFIS_BIT_SC_POS]    = fl.ch2ScPos;
                b[`LFIS_BIT_SC_NEG]    = fl.ch2ScNeg;
                b[`LFIS_BIT_VG_POS]    = fl.ch2VgPos;
                b[`LFIS_BIT_VG_NEG]    = fl.ch2VgNeg;
                b[`LFIS_BIT_REG_MASK]  = mr;
                b[`LFIS_BIT_REG_SHORT] = fl.regShort;
            end
            `LFIS_ADDR_IRQ_HEADSET:
            begin
                b[`LFIS_BIT_HS_INSERT] = fl.hsInsert;
                b[`LFIS_BIT_HS_REMOVE] = fl.hsRemove;
                b[`LFIS_BIT_HS_BUTTON] = fl.hsButton;
            end
            `LFIS_ADDR_IRQ_ANALOG:
            begin
                b[`LFIS_BIT_GPA_UP]   = fl.gpaUp;
                b[`LFIS_BIT_GPA_LOW]  = fl.gpaLow;
                b[`LFIS_BIT_VAD_UP]   = fl.vadUp;
                b[`LFIS_BIT_VAD_DOWN] = fl.vadDown;
            end
            default:
            begin
                b = `LFIS_RST_BYTE;
            end
        endcase
        return b;
    endfunction : readByte

    // ------------------------------------------------------------
    // Latched flags, masks and read answer
    // ------------------------------------------------------------
    lfis_evt_t  latch_r;
    lfis_evt_t  latch_nxt;
    lfis_evt_t  clr;
    lfis_evt_t  effMask;
    logic       regShortMask_r;
    logic       regShortMask_nxt;
    logic       adc1_nxt;
    logic       adc2_nxt;
    logic       irq_nxt;
    lfis_rsp_t  rsp_nxt;
    logic       rd34;
    logic       rd38;
    logic       rd39;
    logic       rd3a;
    logic       rd3b;

    always_comb
    begin
        rd34 = req.rdEn && (req.addr == `LFIS_ADDR_IRQ_CLOCK_PLL);
        rd38 = req.rdEn && (req.addr == `LFIS_ADDR_OUT_CH1);
        rd39 = req.rdEn && (req.addr == `LFIS_ADDR_OUT_CH2);
        rd3a = req.rdEn && (req.addr == `LFIS_ADDR_IRQ_HEADSET);
        rd3b = req.rdEn && (req.addr == `LFIS_ADDR_IRQ_ANALOG);
        // A read clears only the flags of the register it returned
        clr          = '0;
        clr.clkErr   = rd34;
        clr.pllLock  = rd34;
        clr.ch1ScPos = rd38;
        clr.ch1ScNeg = rd38;
        clr.ch1VgPos = rd38;
        clr.ch1VgNeg = rd38;
        clr.ch2ScPos = rd39;
        clr.ch2ScNeg = rd39;
        clr.ch2VgPos = rd39;
        clr.ch2VgNeg = rd39;
        clr.regShort = rd39;
        clr.hsInsert = rd3a;
        clr.hsRemove = rd3a;
        clr.hsButton = rd3a;
        clr.gpaUp    = rd3b;
        clr.gpaLow   = rd3b;
        clr.vadUp    = rd3b;
        clr.vadDown  = rd3b;
        // Set wins over the clear so an event in the read cycle is never lost
        latch_nxt = evt | (latch_r & ~clr);
        // Only the three mask bits take writes; reserved and flag bits ignore them
        adc1_nxt         = adcCh1OverloadMask_r;
        adc2_nxt         = adcCh2OverloadMask_r;
        regShortMask_nxt = regShortMask_r;
        if (req.wrEn && (req.addr == `LFIS_ADDR_OUT_CH1))
        begin
            adc1_nxt = req.wrData[`LFIS_BIT_ADC1_MASK];
            adc2_nxt = req.wrData[`LFIS_BIT_ADC2_MASK];
        end
        if (req.wrEn && (req.addr == `LFIS_ADDR_OUT_CH2))
        begin
            regShortMask_nxt = req.wrData[`LFIS_BIT_REG_MASK];
        end
        effMask          = srcMask;
        effMask.regShort = regShortMask_r;
        irq_nxt          = |(latch_r & ~effMask);
        rsp_nxt.valid    = req.rdEn;
        rsp_nxt.data     = req.rdEn ? readByte(req.addr, latch_r, adcCh1OverloadMask_r,
                                               adcCh2OverloadMask_r, regShortMask_r)
                                    : `LFIS_RST_BYTE;
    end

    always_ff @(posedge clk_sys or negedge rstN)
    begin
        if (!rstN)
        begin
            latch_r              <= '0;
            adcCh1OverloadMask_r <= `LFIS_RST_BIT;
            adcCh2OverloadMask_r <= `LFIS_RST_BIT;
            regShortMask_r       <= `LFIS_RST_BIT;
            faultIrq_r           <= `LFIS_RST_BIT;
            rsp_r                <= '0;
        end
        else
        begin
            latch_r              <= latch_nxt;
            adcCh1OverloadMask_r <= adc1_nxt;
            adcCh2OverloadMask_r <= adc2_nxt;
            regShortMask_r       <= regShortMask_nxt;
            faultIrq_r           <= irq_nxt;
            rsp_r                <= rsp_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    clock_err_set_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        evt.clkErr |=> latch_r.clkErr)
        else $error("Clock error event not latched");

    pll_hold_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        latch_r.pllLock && !rd34 |=> latch_r.pllLock)
        else $error("PLL lock flag dropped without a read");

    ch1_short_read_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd38 |=> rsp_r.valid && rsp_r.data[`LFIS_BIT_SC_POS] == $past(latch_r.ch1ScPos))
        else $error("Channel 1 short flag read back wrong");

    adc1_mask_write_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        req.wrEn && req.addr == `LFIS_ADDR_OUT_CH1
        |=> adcCh1OverloadMask_r == $past(req.wrData[`LFIS_BIT_ADC1_MASK]))
        else $error("ADC channel 1 mask not written");

    reg_mask_write_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        req.wrEn && req.addr == `LFIS_ADDR_OUT_CH2
        |=> regShortMask_r == $past(req.wrData[`LFIS_BIT_REG_MASK]))
        else $error("Regulator mask not written");

    headset_read_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd3a |=> rsp_r.data[`LFIS_BIT_HS_INSERT] == $past(latch_r.hsInsert))
        else $error("Headset insert flag read back wrong");

    reserved_zero_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd34 |=> rsp_r.data[5:0] == 6'h00)
        else $error("Reserved bits not zero");

    irq_gate_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        latch_r.vadUp && !srcMask.vadUp |=> faultIrq_r)
        else $error("Unmasked flag did not raise the interrupt");

    read_clear_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd3b && !evt.gpaUp |=> !latch_r.gpaUp && rsp_r.valid)
        else $error("Flag not cleared by its read");

    adc2_mask_write_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        req.wrEn && req.addr == `LFIS_ADDR_OUT_CH1
        |=> adcCh2OverloadMask_r == $past(req.wrData[`LFIS_BIT_ADC2_MASK]))
        else $error("ADC channel 2 mask not written");

    ch2_short_read_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd39 |=> rsp_r.valid && rsp_r.data[`LFIS_BIT_SC_POS] == $past(latch_r.ch2ScPos))
        else $error("Channel 2 short flag read back wrong");

    reg_short_read_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd39 |=> rsp_r.data[`LFIS_BIT_REG_SHORT] == $past(latch_r.regShort))
        else $error("Regulator short flag read back wrong");

    vad_down_set_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        evt.vadDown |=> latch_r.vadDown)
        else $error("Voice power-down event not latched");

    hs_reserved_zero_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        rd3a |=> rsp_r.data[7:4] == 4'h0)
        else $error("Headset reserved bits not zero");

    irq_quiet_a : assert property (
        @(posedge clk_sys) disable iff (!rstN)
        latch_r == '0 |=> !faultIrq_r)
        else $error("Interrupt raised with no flag latched");

endmodule : lfis_top

// ===== design/lfis_defines.svh
// Register offsets, field positions and reset values of the latched fault status bank
`ifndef LFIS_DEFINES_SVH
`define LFIS_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define LFIS_ADDR_IRQ_CLOCK_PLL   8'h34
`define LFIS_ADDR_OUT_CH1         8'h38
`define LFIS_ADDR_OUT_CH2         8'h39
`define LFIS_ADDR_IRQ_HEADSET     8'h3a
`define LFIS_ADDR_IRQ_ANALOG      8'h3b

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LFIS_BIT_CLK_ERR          7
`define LFIS_BIT_PLL_LOCK         6
`define LFIS_BIT_SC_POS           7
`define LFIS_BIT_SC_NEG           6
`define LFIS_BIT_VG_POS           5
`define LFIS_BIT_VG_NEG           4
`define LFIS_BIT_ADC1_MASK        3
`define LFIS_BIT_ADC2_MASK        2
`define LFIS_BIT_REG_MASK         1
`define LFIS_BIT_REG_SHORT        0
`define LFIS_BIT_HS_INSERT        3
`define LFIS_BIT_HS_REMOVE        2
`define LFIS_BIT_HS_BUTTON        1
`define LFIS_BIT_GPA_UP           7
`define LFIS_BIT_GPA_LOW          6
`define LFIS_BIT_VAD_UP           5
`define LFIS_BIT_VAD_DOWN         4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LFIS_RST_BYTE             8'h00
`define LFIS_RST_BIT              1'b0

`endif

// ===== design/lfis_pkg.sv
// Types shared by the latched fault status bank
package lfis_pkg;

    // One bit per fault or interrupt source; same layout for events, flags and masks
    typedef struct packed {
        logic clkErr;
        logic pllLock;
        logic ch1ScPos;
        logic ch1ScNeg;
        logic ch1VgPos;
        logic ch1VgNeg;
        logic ch2ScPos;
        logic ch2ScNeg;
        logic ch2VgPos;
        logic ch2VgNeg;
        logic regShort;
        logic hsInsert;
        logic hsRemove;
        logic hsButton;
        logic gpaUp;
        logic gpaLow;
        logic vadUp;
        logic vadDown;
    } lfis_evt_t;

    // Register access from the control-bus front end
    typedef struct packed {
        logic       rdEn;
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } lfis_req_t;

    // Read answer, one cycle after the read request
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } lfis_rsp_t;

endpackage : lfis_pkg

// ===== verif/lfis_src_model.sv
// Behavioural fault and event sources that feed the status bank
`timescale 1ns/1ns

module lfis_src_model (
    input  wire logic                clk_sys,
    output      lfis_pkg::lfis_evt_t evtOut
);
    import lfis_pkg::*;

    // ------------------------------------------------------------
    // Source levels
    // ------------------------------------------------------------
    initial evtOut = '0;

    // Falling-edge drive keeps the bank's synchroniser away from a race
    task automatic pulse(input lfis_evt_t e, input int n);
        @(negedge clk_sys);
        evtOut = e;
        repeat (n) @(negedge clk_sys);
        evtOut = '0;
    endtask : pulse

    // A detector that stays asserting, as a lasting fault does
    task automatic hold(input lfis_evt_t e);
        @(negedge clk_sys);
        evtOut = e;
    endtask : hold

endmodule : lfis_src_model

// ===== verif/latched_fault_interrupt_status_tb.sv
// Self-checking bench for the latched fault status bank
`timescale 1ns/1ns

module latched_fault_interrupt_status_tb;
    import lfis_pkg::*;

    // ------------------------------------------------------------
    // Signals and tables
    // ------------------------------------------------------------
    logic       clk_sys   = 1'b0;
    logic       rst_n     = 1'b0;
    lfis_evt_t  evtIn;
    lfis_evt_t  srcMask   = '0;
    lfis_req_t  req       = '0;
    lfis_rsp_t  rsp_r;
    lfis_evt_t  live_r;
    logic       faultIrq_r;
    logic       maskCh1;
    logic       maskCh2;
    int         err_count = 0;
    int         n_tests   = 0;
    logic [7:0] regTab [6]  = '{8'h34, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h35};
    logic [7:0] addrTab [18] = '{8'h34, 8'h34, 8'h38, 8'h38, 8'h38, 8'h38, 8'h39, 8'h39,
                                 8'h39, 8'h39, 8'h39, 8'h3a, 8'h3a, 8'h3a, 8'h3b, 8'h3b,
                                 8'h3b, 8'h3b};
    logic [7:0] bitTab [18]  = '{8'h80, 8'h40, 8'h80, 8'h40, 8'h20, 8'h10, 8'h80, 8'h40,
                                 8'h20, 8'h10, 8'h01, 8'h08, 8'h04, 8'h02, 8'h80, 8'h40,
                                 8'h20, 8'h10};

    always #25 clk_sys = ~clk_sys;

    lfis_src_model lfis_src_model_i (
        .clk_sys (clk_sys),
        .evtOut  (evtIn)
    );

    lfis_top lfis_top_i (
        .clk_sys              (clk_sys),
        .rst_n                (rst_n),
        .evtIn                (evtIn),
        .srcMask              (srcMask),
        .req                  (req),
        .rsp_r                (rsp_r),
        .live_r               (live_r),
        .faultIrq_r           (faultIrq_r),
        .adcCh1OverloadMask_r (maskCh1),
        .adcCh2OverloadMask_r (maskCh2)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %b seen %b", nm, exp, got);
        end
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{rdEn: 1'b0, wrEn: 1'b1, addr: a, wrData: d};
        @(negedge clk_sys);
        req = '0;
    endtask : wr

    // The answer stands for one cycle only, so it is taken at the very next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        req = '{rdEn: 1'b1, wrEn: 1'b0, addr: a, wrData: 8'h00};
        @(negedge clk_sys);
        req = '0;
        chk1("read valid", 1'b1, rsp_r.valid);
        chk8($sformatf("reg %h", a), e, rsp_r.data);
    endtask : rd

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : do_reset

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        do_reset();
        foreach (regTab[i]) rd(regTab[i], 8'h00);
        for (int i = 0; i < 18; i++)
        begin
            lfis_src_model_i.pulse(lfis_evt_t'(18'h20000 >> i), 1);
            repeat (5) @(negedge clk_sys);
            chk1("irq set", 1'b1, faultIrq_r);
            rd(addrTab[i], bitTab[i]);
            rd(addrTab[i], 8'h00);
            chk1("irq clear", 1'b0, faultIrq_r);
        end
        // Source still asserting keeps its flag through reads
        lfis_src_model_i.hold(lfis_evt_t'(18'h00040));
        repeat (4) @(negedge clk_sys);
        chk1("live insert", 1'b1, live_r.hsInsert);
        rd(8'h3a, 8'h08);
        rd(8'h3a, 8'h08);
        lfis_src_model_i.hold('0);
        repeat (5) @(negedge clk_sys);
        rd(8'h3a, 8'h08);
        rd(8'h3a, 8'h00);
        wr(8'h38, 8'hfc);
        rd(8'h38, 8'h0c);
        chk1("mask ch1", 1'b1, maskCh1);
        chk1("mask ch2", 1'b1, maskCh2);
        wr(8'h39, 8'hf2);
        rd(8'h39, 8'h02);
        wr(8'h34, 8'hc0);
        rd(8'h34, 8'h00);
        wr(8'h38, 8'h08);
        chk1("mask ch2", 1'b0, maskCh2);
        lfis_src_model_i.pulse(lfis_evt_t'(18'h00080), 1);
        repeat (5) @(negedge clk_sys);
        chk1("irq masked", 1'b0, faultIrq_r);
        rd(8'h39, 8'h03);
        srcMask = '1;
        lfis_src_model_i.pulse(lfis_evt_t'(18'h20000), 1);
        repeat (5) @(negedge clk_sys);
        chk1("irq masked", 1'b0, faultIrq_r);
        rd(8'h34, 8'h80);
        srcMask = '0;
        lfis_src_model_i.pulse(lfis_evt_t'(18'h00010), 1);
        repeat (5) @(negedge clk_sys);
        chk1("irq set", 1'b1, faultIrq_r);
        do_reset();
        chk1("irq reset", 1'b0, faultIrq_r);
        rd(8'h3a, 8'h00);
        rd(8'h38, 8'h00);
        rd(8'h39, 8'h00);
        chk1("mask ch1", 1'b0, maskCh1);
        close_out();
    end

    // The tests need about 300 cycles; this allows more than ten times that
    initial
    begin
        #250000;
        err_count++;
        $display("unexpected watchdog: expected done seen hang");
        close_out();
    end

endmodule : latched_fault_interrupt_status_tb
